// [hw/sslv_pkg.sv]
// Constants for the synchronous slave serial transceiver.
// Assumes a 32-bit classic Wishbone register bus with one register per aligned word.
package sslv_pkg;
    // Register byte offsets.
    localparam logic [7:0] OFF_RX_STATUS_CONTROL = 8'h00;
    localparam logic [7:0] OFF_TX_STATUS_CONTROL = 8'h04;
    localparam logic [7:0] OFF_RECEIVE_DATA = 8'h08;
    localparam logic [7:0] OFF_TRANSMIT_BUFFER = 8'h0C;
    localparam logic [7:0] OFF_PERIPH_IRQ_ENABLE = 8'h10;
    localparam logic [7:0] OFF_PERIPH_IRQ_FLAGS = 8'h14;
    localparam logic [7:0] OFF_CORE_IRQ_CONTROL = 8'h18;

    // receive_status_control fields.
    localparam int RCS_PORT_EN = 7;
    localparam int RCS_NINE_EN = 6;
    localparam int RCS_SINGLE_EN = 5;
    localparam int RCS_CONT_EN = 4;
    localparam int RCS_ADDR_DET = 3;
    localparam int RCS_FRAME_ERR = 2;
    localparam int RCS_OVERRUN = 1;
    localparam int RCS_NINTH_BIT = 0;

    // transmit_status_control fields.
    localparam int TCS_CLK_SRC = 7;
    localparam int TCS_NINE_EN = 6;
    localparam int TCS_TX_EN = 5;
    localparam int TCS_SYNC = 4;
    localparam int TCS_HIGH_RATE = 2;
    localparam int TCS_SHIFT_EMPTY = 1;
    localparam int TCS_NINTH_BIT = 0;

    // Interrupt enable, flag and core control fields.
    localparam int PIR_RX_FLAG = 5;
    localparam int PIR_TX_FLAG = 4;
    localparam int CIC_GLOBAL_EN = 7;
    localparam int CIC_PERIPH_EN = 6;

    // Reset values and the interrupt vector.
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [15:0] INTERRUPT_VECTOR = 16'h0004;
    localparam logic [15:0] NO_VECTOR = 16'h0000;

    // Character lengths in bits and bit-count steps.
    localparam logic [3:0] BITS_EIGHT = 4'h8;
    localparam logic [3:0] BITS_NINE = 4'h9;
    localparam logic [3:0] CNT_ZERO = 4'h0;
    localparam logic [3:0] CNT_ONE = 4'h1;
endpackage : sslv_pkg

// [hw/pin_sync.sv]
// Three-stage synchroniser for a pin from outside the sys_clk domain.
// Assumes the pin idles low; a change counts once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic pin,
    output logic level_q,
    output logic rise_q,
    output logic fall_q
);
    logic s1_q;
    logic s2_q;
    logic s3_q;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // The first stage feeds only the second, so metastability never reaches logic.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            level_q <= 1'b0;
            rise_q <= 1'b0;
            fall_q <= 1'b0;
        end else begin
            rise_q <= (s2_q == s3_q) && s3_q && !level_q;
            fall_q <= (s2_q == s3_q) && !s3_q && level_q;
            if (s2_q == s3_q) begin
                level_q <= s3_q;
            end
        end
    end
endmodule : pin_sync
`default_nettype wire

// [hw/rx_shifter.sv]
// Receive shift register: collects 8 or 9 bits, least significant first.
// Assumes sample pulses come from the synchronised falling edge of the link clock.
`timescale 1ns/1ps
`default_nettype none
module rx_shifter
    import sslv_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic clear,
    input wire logic sample,
    input wire logic bit_in,
    input wire logic nine,
    output logic [8:0] word_q,
    output logic done_q
);
    logic [8:0] sr_q;
    logic [3:0] cnt_q;
    logic [8:0] sr_d;
    logic [3:0] len;

    assign sr_d = {bit_in, sr_q[8:1]};
    assign len = nine ? BITS_NINE : BITS_EIGHT;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            sr_q <= 9'h000;
            cnt_q <= CNT_ZERO;
            word_q <= 9'h000;
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (clear) begin
                cnt_q <= CNT_ZERO;
            end else if (sample) begin // RL20
                if (cnt_q + CNT_ONE == len) begin
                    cnt_q <= CNT_ZERO;
                    word_q <= nine ? sr_d : {1'b0, sr_d[8:1]};
                    done_q <= 1'b1;
                end else begin
                    cnt_q <= cnt_q + CNT_ONE;
                end
                sr_q <= sr_d;
            end
        end
    end

    count_bound_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        cnt_q < len || clear || $changed(nine)) else $error("bit count past length"); // RL20
endmodule : rx_shifter
`default_nettype wire

// [hw/sslv_serial.sv]
// Synchronous slave serial transceiver with Wishbone registers and sleep wake-up.
// Assumes an external master drives serial_clock_pin idle low and data valid at its fall.
// Contract
// RL1 - Continuous receive keeps receiver never idle.
// RL2 - Single-receive enable has no reception effect.
// RL3 - Completed word moves into receive data register.
// RL4 - Receive flag with enables wakes sleeping core.
// RL5 - Slave mode: sync, port enable, external clock.
// RL6 - Ninth bit to status, low eight to data.
// RL7 - Software keeps address detection cleared.
// RL8 - Receive flag on completion; interrupt if enabled.
// RL9 - Clearing continuous receive clears overrun error.
// RL10 - Only synchronous slave mode shifts during sleep.
// RL11 - Shift registers clocked only by clock pin.
// RL12 - Software empties receive buffer before sleeping.
// RL13 - Sleeping device accepts clocked word, then wakes.
// RL14 - Software fills transmit buffer before sleeping.
// RL15 - After shift-out, reload buffer, set transmit flag.
// RL16 - Writing transmit buffer clears transmit flag.
// RL17 - Wake resumes, or branches to vector 0004h.
// RL18 - Software reads ninth bit before low byte.
// RL19 - Both receive enables clear means transmitter.
// RL20 - Sample data on clock fall, 8/9 bits.
`timescale 1ns/1ps
`default_nettype none
module sslv_serial (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic wb_ack_o,
    output logic [31:0] wb_dat_o,
    input wire logic serial_clock_pin,
    input wire logic serial_data_pin_i,
    output logic serial_data_pin_o,
    output logic serial_data_pin_oe_n,
    input wire logic core_sleep,
    output logic core_wake,
    output logic core_branch,
    output logic [15:0] core_vector
);
    import sslv_pkg::*;

    function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
        hit = (adr[7:2] == off[7:2]);
    endfunction : hit

    logic ack_q;
    logic [31:0] rdat_q;
    logic wb_req;
    logic wb_take;
    logic wr_byte;
    logic [7:0] rd_data;

    logic serial_port_enable_q, rx9_q, single_receive_enable_q, continuous_receive_enable_q, address_detect_enable_q, overrun_error_q, received_ninth_bit_q;
    logic clock_source_select_q, tx9_q, txen_q, sync_q, brgh_q, tx9d_q;
    logic [7:0] pie_q;
    logic [7:0] core_interrupt_control_q;
    logic [7:0] receive_data_q;
    logic receive_flag_q;
    logic [7:0] txbuf_q;
    logic txbuf9_q;
    logic buf_full_q;
    logic [8:0] tsr_q;
    logic [3:0] tsr_cnt_q;
    logic tsr_busy_q;
    logic data_o_q;
    logic oe_n_q;
    logic wake_q;
    logic branch_q;
    logic [15:0] vector_q;

    logic slave_en, rx_mode, tx_mode;
    logic ck_fall;
    logic dt_level;
    logic [8:0] rx_word;
    logic rx_done;
    logic rd_receive_data, wr_txbuf;
    logic accept, overrun;
    logic tx_load;
    logic transmit_flag;
    logic pend;

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;
    assign serial_data_pin_o = data_o_q;
    assign serial_data_pin_oe_n = oe_n_q;
    assign core_wake = wake_q;
    assign core_branch = branch_q;
    assign core_vector = vector_q;

    assign slave_en = serial_port_enable_q && sync_q && !clock_source_select_q; // RL5
    assign rx_mode = slave_en && (single_receive_enable_q || continuous_receive_enable_q); // RL19
    assign tx_mode = slave_en && !single_receive_enable_q && !continuous_receive_enable_q && txen_q; // RL19

    // Pins are synchronised alike so data keeps its set-up margin against the clock.
    pin_sync u_ck_sync (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .pin(serial_clock_pin),
        .level_q(),
        .rise_q(),
        .fall_q(ck_fall)
    );

    pin_sync u_dt_sync (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .pin(serial_data_pin_i),
        .level_q(dt_level),
        .rise_q(),
        .fall_q()
    );

    // Receive runs on link edges alone, so sleep does not stop it; the single-receive
    // enable only selects direction and adds no one-shot behaviour.
    rx_shifter u_rx (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .clear(!rx_mode), // RL1 RL2
        .sample(ck_fall), // RL11 RL13
        .bit_in(dt_level),
        .nine(rx9_q),
        .word_q(rx_word),
        .done_q(rx_done)
    );

    // Wishbone: ack one cycle after the request; effects occur on the acked edge.
    assign wb_req = wb_cyc_i && wb_stb_i;
    assign wb_take = wb_req && ack_q;
    assign wr_byte = wb_take && wb_we_i && wb_sel_i[0];
    assign rd_receive_data = wb_take && !wb_we_i && hit(wb_adr_i, OFF_RECEIVE_DATA);
    assign wr_txbuf = wr_byte && hit(wb_adr_i, OFF_TRANSMIT_BUFFER);

    always_comb begin
        rd_data = RST_BYTE;
        if (hit(wb_adr_i, OFF_RX_STATUS_CONTROL)) begin
            rd_data = {serial_port_enable_q, rx9_q, single_receive_enable_q, continuous_receive_enable_q, address_detect_enable_q, 1'b0, overrun_error_q, received_ninth_bit_q};
        end else if (hit(wb_adr_i, OFF_TX_STATUS_CONTROL)) begin
            rd_data = {clock_source_select_q, tx9_q, txen_q, sync_q, 1'b0, brgh_q, !tsr_busy_q, tx9d_q};
        end else if (hit(wb_adr_i, OFF_RECEIVE_DATA)) begin
            rd_data = receive_data_q;
        end else if (hit(wb_adr_i, OFF_PERIPH_IRQ_ENABLE)) begin
            rd_data = pie_q;
        end else if (hit(wb_adr_i, OFF_PERIPH_IRQ_FLAGS)) begin
            rd_data = {2'b00, receive_flag_q, transmit_flag, 4'h0};
        end else if (hit(wb_adr_i, OFF_CORE_IRQ_CONTROL)) begin
            rd_data = core_interrupt_control_q;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            ack_q <= 1'b0;
            rdat_q <= RST_WORD;
        end else begin
            ack_q <= wb_req && !ack_q;
            if (wb_req && !ack_q) begin
                rdat_q <= {24'h00_0000, rd_data};
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            {serial_port_enable_q, rx9_q, single_receive_enable_q, continuous_receive_enable_q, address_detect_enable_q} <= 5'h00;
            {clock_source_select_q, tx9_q, txen_q, sync_q, brgh_q, tx9d_q} <= 6'h00;
            pie_q <= RST_BYTE;
            core_interrupt_control_q <= RST_BYTE;
        end else if (wr_byte) begin
            if (hit(wb_adr_i, OFF_RX_STATUS_CONTROL)) begin
                serial_port_enable_q <= wb_dat_i[RCS_PORT_EN];
                rx9_q <= wb_dat_i[RCS_NINE_EN];
                single_receive_enable_q <= wb_dat_i[RCS_SINGLE_EN];
                continuous_receive_enable_q <= wb_dat_i[RCS_CONT_EN];
                address_detect_enable_q <= wb_dat_i[RCS_ADDR_DET]; // RL7
            end
            if (hit(wb_adr_i, OFF_TX_STATUS_CONTROL)) begin
                clock_source_select_q <= wb_dat_i[TCS_CLK_SRC];
                tx9_q <= wb_dat_i[TCS_NINE_EN];
                txen_q <= wb_dat_i[TCS_TX_EN];
                sync_q <= wb_dat_i[TCS_SYNC];
                brgh_q <= wb_dat_i[TCS_HIGH_RATE];
                tx9d_q <= wb_dat_i[TCS_NINTH_BIT];
            end
            if (hit(wb_adr_i, OFF_PERIPH_IRQ_ENABLE)) begin
                pie_q <= wb_dat_i[7:0];
            end
            if (hit(wb_adr_i, OFF_CORE_IRQ_CONTROL)) begin
                core_interrupt_control_q <= wb_dat_i[7:0];
            end
        end
    end

    // Single-entry buffer: with continuous receive set, a word completing while the flag is still pending is an overrun.
    assign accept = rx_done && (!receive_flag_q || rd_receive_data) && !overrun_error_q;
    assign overrun = rx_done && receive_flag_q && !rd_receive_data && continuous_receive_enable_q;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            receive_data_q <= RST_BYTE;
            received_ninth_bit_q <= 1'b0;
            receive_flag_q <= 1'b0;
            overrun_error_q <= 1'b0;
        end else begin
            if (accept) begin
                receive_data_q <= rx_word[7:0]; // RL3
                received_ninth_bit_q <= rx9_q && rx_word[8]; // RL6
            end
            receive_flag_q <= accept || (receive_flag_q && !rd_receive_data && serial_port_enable_q); // RL8
            if (!continuous_receive_enable_q || !serial_port_enable_q) begin
                overrun_error_q <= 1'b0; // RL9
            end else if (overrun) begin
                overrun_error_q <= 1'b1;
            end
        end
    end

    // Transmit: the flag is the emptiness of the buffer, so a buffer write clears it while the port is enabled.
    assign transmit_flag = !buf_full_q;
    assign tx_load = tx_mode && buf_full_q && !tsr_busy_q;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            txbuf_q <= RST_BYTE;
            txbuf9_q <= 1'b0;
            buf_full_q <= 1'b0;
        end else begin
            if (wr_txbuf) begin
                txbuf_q <= wb_dat_i[7:0];
                txbuf9_q <= tx9d_q;
            end
            buf_full_q <= serial_port_enable_q && (wr_txbuf || (buf_full_q && !tx_load)); // RL15 RL16
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            tsr_q <= 9'h000;
            tsr_cnt_q <= CNT_ZERO;
            tsr_busy_q <= 1'b0;
            data_o_q <= 1'b1;
            oe_n_q <= 1'b1;
        end else begin
            oe_n_q <= !tx_mode;
            if (!tx_mode) begin
                tsr_busy_q <= 1'b0;
                data_o_q <= 1'b1;
            end else if (tx_load) begin
                tsr_q <= {txbuf9_q, txbuf_q}; // RL15
                tsr_cnt_q <= tx9_q ? BITS_NINE : BITS_EIGHT;
                tsr_busy_q <= 1'b1;
                data_o_q <= txbuf_q[0];
            end else if (tsr_busy_q && ck_fall) begin // RL11
                tsr_q <= {1'b0, tsr_q[8:1]};
                tsr_cnt_q <= tsr_cnt_q - CNT_ONE;
                data_o_q <= tsr_q[1];
                if (tsr_cnt_q == CNT_ONE) begin
                    tsr_busy_q <= 1'b0;
                end
            end
        end
    end

    // Only the slave mode is built, so nothing here depends on the core clock pausing.
    assign pend = core_interrupt_control_q[CIC_PERIPH_EN]
        && ((receive_flag_q && pie_q[PIR_RX_FLAG]) || (transmit_flag && pie_q[PIR_TX_FLAG]));

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            wake_q <= 1'b0;
            branch_q <= 1'b0;
            vector_q <= NO_VECTOR;
        end else begin
            wake_q <= core_sleep && pend; // RL4 RL10 RL13
            branch_q <= pend && core_interrupt_control_q[CIC_GLOBAL_EN]; // RL17
            vector_q <= (pend && core_interrupt_control_q[CIC_GLOBAL_EN]) ? INTERRUPT_VECTOR : NO_VECTOR;
        end
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);

    sequence tx_reload_s;
        tx_load ##1 (tsr_busy_q && transmit_flag) ##1 !oe_n_q;
    endsequence

    sequence rx_accept_s;
        accept ##1 (receive_flag_q && receive_data_q == $past(rx_word[7:0]));
    endsequence

    rx_word_move_a: assert property (accept |-> rx_accept_s) // RL3
        else $error("received word not moved to data register");
    ninth_bit_a: assert property (accept && rx9_q |=> received_ninth_bit_q == $past(rx_word[8])) // RL6
        else $error("ninth bit not presented");
    rx_flag_cause_a: assert property ($rose(receive_flag_q) |-> $past(rx_done)) // RL8
        else $error("receive flag set without a word");
    overrun_clear_a: assert property (!continuous_receive_enable_q |=> !overrun_error_q) // RL9
        else $error("overrun kept with continuous receive clear");
    tx_reload_a: assert property (tx_load |-> tx_reload_s) // RL15
        else $error("transmit buffer not reloaded");
    tx_write_clear_a: assert property (wr_txbuf && serial_port_enable_q |=> !transmit_flag) // RL16
        else $error("buffer write left transmit flag set");
    rx_wake_a: assert property (core_sleep && receive_flag_q && pie_q[PIR_RX_FLAG]
        && core_interrupt_control_q[CIC_PERIPH_EN] |=> wake_q) // RL4
        else $error("receive flag did not wake core");
    vector_branch_a: assert property (branch_q |-> vector_q == INTERRUPT_VECTOR) // RL17
        else $error("branch without interrupt vector");
    tx_shift_edge_a: assert property (tsr_busy_q && !tx_load && !$past(tx_load) && tx_mode
        && $past(tx_mode) && tsr_cnt_q != $past(tsr_cnt_q) |-> $past(ck_fall)) // RL11
        else $error("transmit shift without link clock fall");
    direction_a: assert property ((single_receive_enable_q || continuous_receive_enable_q) |=> oe_n_q) // RL19
        else $error("data pin driven while receiving");
    ack_pulse_a: assert property (ack_q |=> !ack_q)
        else $error("ack held longer than one cycle");
endmodule : sslv_serial
`default_nettype wire

// [testbench/link_master.sv]
// Behavioural external master that clocks the synchronous slave link.
// Assumes the bench resolves the data wire and feeds the resolved level back on line_i.
`timescale 1ns/1ps
`default_nettype none
module link_master (
    input wire logic line_i,
    output logic clk_o,
    output logic line_o
);
    logic drv_q;
    logic dat_q;
    logic idle_q;
    initial begin
        clk_o = 1'b0;
        drv_q = 1'b0;
        dat_q = 1'b0;
        idle_q = 1'b0;
    end
    // A released line keeps changing, so a stale level can never pass for data.
    always #40 idle_q = ~idle_q;
    assign line_o = drv_q ? dat_q : idle_q;
    // The clock runs only inside a frame and rests low between frames.
    task automatic frame(input int nbits, input int half, input logic drive,
                         input logic [8:0] wd, output logic [8:0] rd);
        rd = 9'h000;
        #7;
        drv_q = drive;
        for (int i = 0; i < nbits; i++) begin
            #(half) clk_o = 1'b1;
            // Data moves on the rise, so it is settled long before the slave sees the fall.
            dat_q = wd[i];
            #(half) rd[i] = line_i;
            clk_o = 1'b0;
        end
        // Data is held for a further half period after the last fall.
        #(half) drv_q = 1'b0;
    endtask : frame
endmodule : link_master
`default_nettype wire

// [testbench/tb.sv]
// Self-checking bench for the synchronous slave serial transceiver.
// Assumes the design's Wishbone port and the link_master partner model.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import sslv_pkg::*;
    localparam logic [31:0] ONE = 32'h0000_0001;
    localparam logic [31:0] RXF = ONE << PIR_RX_FLAG;
    localparam logic [31:0] TXF = ONE << PIR_TX_FLAG;
    localparam logic [31:0] PEF = ONE << CIC_PERIPH_EN;
    localparam logic [31:0] GEF = ONE << CIC_GLOBAL_EN;
    localparam logic [31:0] PORT = ONE << RCS_PORT_EN;
    localparam logic [31:0] CONT = ONE << RCS_CONT_EN;
    localparam logic [31:0] RX_CFG = PORT | CONT | (ONE << RCS_SINGLE_EN);
    localparam logic [31:0] NINE = ONE << RCS_NINE_EN;
    localparam logic [31:0] OVR = ONE << RCS_OVERRUN;
    logic sys_clk;
    logic rst_b;
    logic wb_cyc_i;
    logic wb_stb_i;
    logic wb_we_i;
    logic [7:0] wb_adr_i;
    logic [31:0] wb_dat_i;
    logic [3:0] wb_sel_i;
    logic wb_ack_o;
    logic [31:0] wb_dat_o;
    logic link_clk;
    logic m_line;
    logic data_in;
    logic data_out;
    logic data_oe_n;
    logic core_sleep;
    logic core_wake;
    logic core_branch;
    logic [15:0] core_vector;
    logic [31:0] exp_q[$];
    logic [7:0] rst_tab[6];
    logic [8:0] rd;
    logic [8:0] w;
    logic [7:0] a;
    logic [7:0] b;
    int n_fail;
    int cmp_count;
    sslv_serial i_dut (.sys_clk(sys_clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
        .wb_sel_i(wb_sel_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
        .serial_clock_pin(link_clk), .serial_data_pin_i(data_in),
        .serial_data_pin_o(data_out), .serial_data_pin_oe_n(data_oe_n),
        .core_sleep(core_sleep), .core_wake(core_wake), .core_branch(core_branch),
        .core_vector(core_vector));
    link_master i_master (.line_i(data_in), .clk_o(link_clk), .line_o(m_line));
    assign data_in = (data_oe_n === 1'b0) ? data_out : m_line;
    initial sys_clk = 1'b0;
    always #20 sys_clk = ~sys_clk;
    task automatic results();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : results
    task automatic cmp_val(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : cmp_val
    // Read data is judged here against the oldest expectation noted by the driver.
    always @(posedge sys_clk) begin
        if (wb_ack_o === 1'b1 && wb_cyc_i && !wb_we_i) begin
            if (exp_q.size() == 0) begin
                n_fail++;
                $display("Error read data expected none seen %h", wb_dat_o);
            end else begin
                cmp_val("read data", exp_q.pop_front(), wb_dat_o);
            end
        end
    end
    task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                            input logic [3:0] sel);
        int n;
        n = 0;
        @(posedge sys_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        wb_sel_i <= sel;
        do begin
            @(posedge sys_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        if (n >= 50) begin
            n_fail++;
            $display("Error bus ack expected 1 seen %b", wb_ack_o);
            results();
        end
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask : wb_cycle
    task automatic wb_write(input logic [7:0] adr, input logic [31:0] dat);
        wb_cycle(1'b1, adr, dat, 4'hF);
    endtask : wb_write
    task automatic wb_read(input logic [7:0] adr, input logic [31:0] exp);
        exp_q.push_back(exp);
        wb_cycle(1'b0, adr, 32'h0000_0000, 4'hF);
    endtask : wb_read
    task automatic cmp_core(input logic wake, input logic branch);
        cmp_val("core_wake", {31'h0, wake}, {31'h0, core_wake});
        cmp_val("core_branch", {31'h0, branch}, {31'h0, core_branch});
        cmp_val("core_vector", {16'h0, branch ? INTERRUPT_VECTOR : NO_VECTOR},
                {16'h0, core_vector});
    endtask : cmp_core
    task automatic rx_word(input int nbits, input int half, input logic [8:0] wd);
        i_master.frame(nbits, half, 1'b1, wd, rd);
        repeat (12) @(posedge sys_clk);
    endtask : rx_word
    initial begin
        rst_b = 1'b0;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 8'h00;
        wb_dat_i = 32'h0000_0000;
        wb_sel_i = 4'h0;
        core_sleep = 1'b0;
        n_fail = 0;
        cmp_count = 0;
        rst_tab = '{OFF_RX_STATUS_CONTROL, OFF_RECEIVE_DATA, OFF_PERIPH_IRQ_ENABLE,
                    OFF_CORE_IRQ_CONTROL, 8'h1C, OFF_PERIPH_IRQ_FLAGS};
        w = 9'($urandom(36340));
        repeat (12) @(posedge sys_clk);
        rst_b <= 1'b1;
        foreach (rst_tab[i]) wb_read(rst_tab[i], (i == 5) ? TXF : RST_WORD);
        wb_cycle(1'b1, OFF_PERIPH_IRQ_ENABLE, 32'h0000_00FF, 4'hE);
        wb_read(OFF_PERIPH_IRQ_ENABLE, RST_WORD);
        // Receive while asleep, with the single-receive enable also set.
        wb_write(OFF_TX_STATUS_CONTROL, ONE << TCS_SYNC);
        wb_write(OFF_RX_STATUS_CONTROL, RX_CFG);
        wb_write(OFF_PERIPH_IRQ_ENABLE, RXF);
        wb_write(OFF_CORE_IRQ_CONTROL, PEF);
        cmp_val("data_oe_n", 32'h0000_0001, {31'h0, data_oe_n});
        core_sleep <= 1'b1;
        a = 8'($urandom);
        rx_word(8, 160, {1'b0, a});
        cmp_core(1'b1, 1'b0);
        wb_read(OFF_PERIPH_IRQ_FLAGS, RXF | TXF);
        wb_read(OFF_RX_STATUS_CONTROL, RX_CFG);
        wb_read(OFF_RECEIVE_DATA, {24'h0, a});
        wb_read(OFF_PERIPH_IRQ_FLAGS, TXF);
        cmp_core(1'b0, 1'b0);
        // Two words without a read: the second overruns and is dropped.
        core_sleep <= 1'b0;
        a = 8'($urandom);
        b = ~a;
        rx_word(8, 160, {1'b0, a});
        rx_word(8, 160, {1'b0, b});
        cmp_core(1'b0, 1'b0);
        wb_read(OFF_RX_STATUS_CONTROL, RX_CFG | OVR);
        wb_read(OFF_RECEIVE_DATA, {24'h0, a});
        wb_write(OFF_RX_STATUS_CONTROL, RX_CFG & ~CONT);
        wb_read(OFF_RX_STATUS_CONTROL, RX_CFG & ~CONT);
        // Nine-bit word with the global enable set, so the core branches.
        wb_write(OFF_RX_STATUS_CONTROL, RX_CFG | NINE);
        wb_write(OFF_CORE_IRQ_CONTROL, PEF | GEF);
        w = 9'($urandom);
        rx_word(9, 160, w);
        cmp_core(1'b0, 1'b1);
        wb_read(OFF_RX_STATUS_CONTROL, RX_CFG | NINE | {31'h0, w[8]});
        wb_read(OFF_RECEIVE_DATA, {24'h0, w[7:0]});
        repeat (2) @(posedge sys_clk);
        cmp_core(1'b0, 1'b0);
        // Transmit while asleep: two words queued, reload after the first.
        wb_write(OFF_RX_STATUS_CONTROL, PORT);
        wb_write(OFF_TX_STATUS_CONTROL, (ONE << TCS_SYNC) | (ONE << TCS_TX_EN));
        wb_write(OFF_PERIPH_IRQ_ENABLE, TXF);
        wb_write(OFF_CORE_IRQ_CONTROL, PEF);
        cmp_val("data_oe_n", 32'h0000_0000, {31'h0, data_oe_n});
        a = 8'($urandom);
        b = 8'($urandom);
        wb_write(OFF_TRANSMIT_BUFFER, {24'h0, a});
        wb_write(OFF_TRANSMIT_BUFFER, {24'h0, b});
        core_sleep <= 1'b1;
        wb_read(OFF_PERIPH_IRQ_FLAGS, RST_WORD);
        cmp_core(1'b0, 1'b0);
        i_master.frame(8, 160, 1'b0, 9'h000, rd);
        cmp_val("tx word", {24'h0, a}, {24'h0, rd[7:0]});
        repeat (12) @(posedge sys_clk);
        wb_read(OFF_PERIPH_IRQ_FLAGS, TXF);
        cmp_core(1'b1, 1'b0);
        i_master.frame(8, 160, 1'b0, 9'h000, rd);
        cmp_val("tx word", {24'h0, b}, {24'h0, rd[7:0]});
        repeat (4) @(posedge sys_clk);
        results();
    end
endmodule : tb
`default_nettype wire
